// ### src/sdcc_cmd_decode.sv
// command/address decoder with clock stop and exit guard
// Contract
// [R1] clock change with cke low: refresh only
// [R2] row open/close done and delays expired
// [R3] keep clock two cycles after cke low
// [R4] two clean cycles before cke rises
// [R5] each period within min and max
// [R6] stopped clock: true low, complement high
// [R7] cke high change: all commands completed
// [R8] chip select high during cke-high change
// [R9] commands accepted after two clocks plus exit
// [R10] controller rewrites mode settings after change
// [R11] no-operation needs constant cke level
// [R12] nop: select high, or ca0-2 high
// [R13] nop never aborts running operation
// [R14] illegal events need full reinitialization
// [R15] opcode from select and ca0-3 rising
// [R16] mode write address and data fields
// [R17] activate row and bank fields
// [R18] read/write column, auto close, all banks
// [R19] select, cke rising; ca both edges
// [R20] column bit zero always zero
`timescale 1ns/1ps
`default_nettype none
module sdcc_cmd_decode #(
  parameter int STOP_CYC = 4,
  parameter int XP_NS = sdcc_pkg::XP_NS
) (
  input wire logic core_clk_i, // core clock
  input wire logic rst_i, // async reset, high
  input wire logic link_clk_i, // true memory clock
  input wire logic cs_n_i, // chip select, low active
  input wire logic cke_i, // clock enable
  input wire logic [sdcc_pkg::CA_W-1:0] ca_i, // command/address
  output logic cmd_valid_o, // accepted command pulse
  output logic cmd_refused_o, // refused command pulse
  output var sdcc_pkg::sdcc_cmd_e cmd_code_o, // command code
  output logic [sdcc_pkg::BANK_W-1:0] bank_o, // bank
  output logic [sdcc_pkg::ROW_W-1:0] row_o, // row
  output logic [sdcc_pkg::COL_W-1:0] col_o, // column
  output logic auto_close_flag_o, // auto close
  output logic all_banks_select_o, // all banks
  output logic [sdcc_pkg::MA_W-1:0] mode_reg_address_o, // mode reg address
  output logic [sdcc_pkg::OP_W-1:0] mode_reg_data_o, // mode reg data
  output logic clk_stopped_o, // link clock idle
  output logic exit_wait_o, // exit guard active
  output logic illegal_o, // sticky illegal seen
  output logic overrun_o // sticky command lost
);
  import sdcc_pkg::*;

  localparam int XP_RAW = (XP_NS + CORE_NS - 1) / CORE_NS;
  localparam int XP_CYC = (XP_RAW < 1) ? 1 : XP_RAW;
  localparam int IW = $clog2(STOP_CYC + 1);
  localparam int XW = $clog2(XP_CYC + 1);

  generate
    if (STOP_CYC < 2) begin : g_bad_stop
      $error("STOP_CYC must be at least 2");
    end
  endgenerate

  function automatic sdcc_cmd_e decode_op(input logic cs_n, input logic ck_prev,
                                          input logic ck_now, input logic [3:0] ca);
    sdcc_cmd_e op;
    op = CMD_ILL;
    if (ck_prev && !ck_now)
    begin
      if (cs_n)
        op = CMD_PDE;
      else if (!ca[0] && !ca[1] && ca[2])
        op = CMD_SRE;
      else if (ca[0] && ca[1] && !ca[2])
        op = CMD_DPD;
    end
    else if (!ck_prev && !ck_now)
      op = CMD_NOP;
    else if (!ck_prev)
      op = cs_n ? CMD_PDX : CMD_ILL;
    else if (cs_n || (ca[0] && ca[1] && ca[2]))
      op = CMD_NOP; // [R12]
    else if (!ca[0] && !ca[1])
    begin
      if (!ca[2])
        op = ca[3] ? CMD_MRR : CMD_MRW; // [R15]
      else
        op = ca[3] ? CMD_ALL_BANK_REFRESH : CMD_PER_BANK_REFRESH; // [R15]
    end
    else if (!ca[0])
      op = CMD_ACT; // [R15]
    else if (!ca[1])
      op = ca[2] ? CMD_RD : CMD_WR; // [R15]
    else
      op = ca[3] ? CMD_PRE : CMD_BST; // [R15]
    return op;
  endfunction : decode_op

  // link domain
  logic lk_cs_n_r;
  logic lk_cke_r;
  logic lk_cke_prev_r;
  logic [CA_W-1:0] lk_rise_r;
  logic lk_hb_r;
  logic lk_ack_s1_r;
  logic lk_ack_s2_r;
  logic lk_req_r;
  logic lk_ovr_r;
  sdcc_cmd_e lk_op_r;
  logic [CA_W-1:0] lk_wrise_r;
  logic [CA_W-1:0] lk_wfall_r;
  sdcc_cmd_e lk_op;
  logic lk_pend;
  logic cr_seen_r; // core side, returned as ack

  // rising edge: select, cke and first half of ca
  always_ff @(posedge link_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lk_cs_n_r <= 1'b1;
      lk_cke_r <= 1'b1;
      lk_cke_prev_r <= 1'b1;
      lk_rise_r <= '0;
      lk_hb_r <= 1'b0;
    end
    else
    begin
      lk_cs_n_r <= cs_n_i; // [R19]
      lk_cke_prev_r <= lk_cke_r;
      lk_cke_r <= cke_i; // [R19]
      lk_rise_r <= ca_i; // [R19]
      lk_hb_r <= ~lk_hb_r;
    end
  end

  always_ff @(posedge link_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lk_ack_s1_r <= 1'b0;
      lk_ack_s2_r <= 1'b0;
    end
    else
    begin
      lk_ack_s1_r <= cr_seen_r;
      lk_ack_s2_r <= lk_ack_s1_r;
    end
  end

  assign lk_op = decode_op(lk_cs_n_r, lk_cke_prev_r, lk_cke_r, lk_rise_r[3:0]);
  assign lk_pend = lk_req_r ^ lk_ack_s2_r;

  // falling edge completes the command; nops are never forwarded
  always_ff @(negedge link_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lk_req_r <= 1'b0;
      lk_ovr_r <= 1'b0;
      lk_op_r <= CMD_NOP;
      lk_wrise_r <= '0;
      lk_wfall_r <= '0;
    end
    else if (lk_op != CMD_NOP) // [R13]
    begin
      if (lk_pend)
        lk_ovr_r <= 1'b1;
      else
      begin
        lk_op_r <= lk_op;
        lk_wrise_r <= lk_rise_r;
        lk_wfall_r <= ca_i; // [R19]
        lk_req_r <= ~lk_req_r;
      end
    end
  end

  // core domain
  logic cr_req_s1_r;
  logic cr_req_s2_r;
  logic cr_hb_s1_r;
  logic cr_hb_s2_r;
  logic cr_hb_d_r;
  logic cr_ovr_s1_r;
  logic cr_ovr_s2_r;
  logic [IW-1:0] idle_r;
  logic [IW-1:0] idle_nxt;
  logic [1:0] ed_r;
  logic [1:0] ed_nxt;
  logic [XW-1:0] xp_r;
  logic [XW-1:0] xp_nxt;
  sdcc_gst_e gst_r;
  sdcc_gst_e gst_nxt;
  logic cap;
  logic hb_chg;
  logic stop_hit;
  logic acc;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cr_req_s1_r <= 1'b0;
      cr_req_s2_r <= 1'b0;
      cr_seen_r <= 1'b0;
      cr_hb_s1_r <= 1'b0;
      cr_hb_s2_r <= 1'b0;
      cr_hb_d_r <= 1'b0;
      cr_ovr_s1_r <= 1'b0;
      cr_ovr_s2_r <= 1'b0;
    end
    else
    begin
      cr_req_s1_r <= lk_req_r;
      cr_req_s2_r <= cr_req_s1_r;
      cr_seen_r <= cr_req_s2_r;
      cr_hb_s1_r <= lk_hb_r;
      cr_hb_s2_r <= cr_hb_s1_r;
      cr_hb_d_r <= cr_hb_s2_r;
      cr_ovr_s1_r <= lk_ovr_r;
      cr_ovr_s2_r <= cr_ovr_s1_r;
    end
  end

  assign cap = cr_req_s2_r ^ cr_seen_r;
  assign hb_chg = cr_hb_s2_r ^ cr_hb_d_r;
  assign stop_hit = (idle_nxt == IW'(STOP_CYC));
  assign acc = cap && ((gst_r == G_RUN) || (lk_op_r == CMD_PDX)); // [R9]

  always_comb
  begin
    if (hb_chg)
      idle_nxt = '0;
    else if (idle_r == IW'(STOP_CYC))
      idle_nxt = idle_r;
    else
      idle_nxt = idle_r + 1'b1;
  end

  // exit guard: wait two link edges, then the power-down exit delay
  always_comb
  begin
    gst_nxt = gst_r;
    ed_nxt = ed_r;
    xp_nxt = xp_r;
    case (gst_r)
      G_RUN:
        if (stop_hit)
          gst_nxt = G_STOP;
        else if (cap && lk_op_r == CMD_PDX)
        begin
          gst_nxt = G_EDGE; // [R9]
          ed_nxt = '0;
        end
      G_STOP:
        if (hb_chg)
        begin
          gst_nxt = G_EDGE;
          ed_nxt = 2'h1;
        end
      G_EDGE:
        if (stop_hit)
          gst_nxt = G_STOP;
        else if (ed_r == ABS_EDGES)
        begin
          gst_nxt = G_XP; // [R9]
          xp_nxt = '0;
        end
        else if (hb_chg)
          ed_nxt = ed_r + 2'h1;
      G_XP:
        if (stop_hit)
          gst_nxt = G_STOP;
        else if (xp_r == XW'(XP_CYC - 1))
          gst_nxt = G_RUN; // [R9]
        else
          xp_nxt = xp_r + 1'b1;
      default:
        gst_nxt = G_RUN;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      idle_r <= '0;
      ed_r <= '0;
      xp_r <= '0;
      gst_r <= G_RUN;
      clk_stopped_o <= 1'b0;
      exit_wait_o <= 1'b0;
      overrun_o <= 1'b0;
    end
    else
    begin
      idle_r <= idle_nxt;
      ed_r <= ed_nxt;
      xp_r <= xp_nxt;
      gst_r <= gst_nxt;
      clk_stopped_o <= stop_hit;
      exit_wait_o <= (gst_nxt != G_RUN);
      overrun_o <= cr_ovr_s2_r;
    end
  end

  // field extraction from the two halves of the command
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cmd_valid_o <= 1'b0;
      cmd_refused_o <= 1'b0;
      illegal_o <= 1'b0;
      cmd_code_o <= CMD_NOP;
      bank_o <= '0;
      row_o <= '0;
      col_o <= '0;
      auto_close_flag_o <= 1'b0;
      all_banks_select_o <= 1'b0;
      mode_reg_address_o <= '0;
      mode_reg_data_o <= '0;
    end
    else
    begin
      cmd_valid_o <= acc;
      cmd_refused_o <= cap && !acc;
      if (cap && lk_op_r == CMD_ILL)
        illegal_o <= 1'b1;
      if (cap)
      begin
        cmd_code_o <= lk_op_r;
        bank_o <= lk_wrise_r[BANK_LO +: BANK_W]; // [R17]
        row_o <= {lk_wfall_r[ROW_HI_LO +: ROW_HI_W], lk_wrise_r[ROW_R_LO +: ROW_R_W],
                  lk_wfall_r[0 +: ROW_F_W]}; // [R17]
        col_o <= {lk_wfall_r[CA_W-1:COL_F_LO], lk_wrise_r[COL_R_LO +: COL_R_W],
                  1'b0}; // [R18] [R20]
        auto_close_flag_o <= lk_wfall_r[AP_BIT]; // [R18]
        all_banks_select_o <= lk_wrise_r[AB_BIT]; // [R18]
        mode_reg_address_o <= {lk_wfall_r[0 +: MA_F_W], lk_wrise_r[MA_R_LO +: MA_R_W]}; // [R16]
        mode_reg_data_o <= (lk_op_r == CMD_MRW) ? lk_wfall_r[OP_F_LO +: OP_W] : '0; // [R16]
      end
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_req_arrives;
    cr_req_s2_r != cr_seen_r;
  endsequence
  sequence s_answer;
    cmd_valid_o || cmd_refused_o;
  endsequence

  answer_follows_a: assert property (s_req_arrives |=> s_answer) // [R15]
    else $error("captured command produced no answer");
  valid_refused_excl_a: assert property (!(cmd_valid_o && cmd_refused_o)) // [R9]
    else $error("command both accepted and refused");
  guard_refuse_a: assert property ((gst_r != G_RUN && cap && lk_op_r != CMD_PDX)
    |=> cmd_refused_o && !cmd_valid_o) // [R9]
    else $error("command accepted during exit guard");
  col_lsb_zero_a: assert property ((cmd_valid_o && (cmd_code_o == CMD_RD))
    |-> col_o[0] == 1'b0) // [R20]
    else $error("column bit zero not zero");
  mrr_no_data_a: assert property ((cmd_valid_o && cmd_code_o == CMD_MRR)
    |-> mode_reg_data_o == '0) // [R16]
    else $error("mode read carries data");
  stop_detect_a: assert property ((idle_r == IW'(STOP_CYC - 1) && !hb_chg)
    |=> clk_stopped_o ##1 exit_wait_o) // [R9]
    else $error("stopped clock not detected");
  exit_release_a: assert property ($fell(exit_wait_o)
    |-> $past(gst_r) == G_XP && $past(xp_r) == XW'(XP_CYC - 1)) // [R9]
    else $error("guard released before exit delay");
  pdx_guard_a: assert property ((gst_r == G_RUN && cap && lk_op_r == CMD_PDX && !stop_hit)
    |=> exit_wait_o [*2]) // [R9]
    else $error("power-down exit did not start guard");
  nop_not_sent_a: assert property (@(negedge link_clk_i) disable iff (rst_i)
    $changed(lk_req_r) |-> lk_op_r != CMD_NOP) // [R12]
    else $error("nop forwarded as command");
endmodule : sdcc_cmd_decode
`default_nettype wire

// ### src/sdcc_pkg.sv
// shared constants and types for the command decode front end
package sdcc_pkg;
  localparam int CA_W = 10;
  localparam int CORE_NS = 50;
  localparam int XP_NS = 8;
  localparam logic [1:0] ABS_EDGES = 2'h2;
  localparam int BANK_LO = 7;
  localparam int BANK_W = 3;
  localparam int ROW_R_LO = 2;
  localparam int ROW_R_W = 5;
  localparam int ROW_F_W = 8;
  localparam int ROW_HI_LO = 8;
  localparam int ROW_HI_W = 2;
  localparam int ROW_W = 15;
  localparam int COL_R_LO = 5;
  localparam int COL_R_W = 2;
  localparam int COL_F_LO = 1;
  localparam int COL_W = 12;
  localparam int AP_BIT = 0;
  localparam int AB_BIT = 4;
  localparam int MA_R_LO = 4;
  localparam int MA_R_W = 6;
  localparam int MA_F_W = 2;
  localparam int MA_W = 8;
  localparam int OP_F_LO = 2;
  localparam int OP_W = 8;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_MRW = 4'h1,
    CMD_MRR = 4'h2,
    CMD_PER_BANK_REFRESH = 4'h3,
    CMD_ALL_BANK_REFRESH = 4'h4,
    CMD_ACT = 4'h5,
    CMD_WR = 4'h6,
    CMD_RD = 4'h7,
    CMD_PRE = 4'h8,
    CMD_BST = 4'h9,
    CMD_SRE = 4'hA,
    CMD_DPD = 4'hB,
    CMD_PDE = 4'hC,
    CMD_PDX = 4'hD,
    CMD_ILL = 4'hE
  } sdcc_cmd_e;

  typedef enum logic [1:0] {
    G_RUN = 2'b00,
    G_STOP = 2'b01,
    G_EDGE = 2'b10,
    G_XP = 2'b11
  } sdcc_gst_e;
endpackage : sdcc_pkg

// ### test/sdcc_mc_model.sv
// memory controller model: link clock and command bus driver
`timescale 1ns/1ps
`default_nettype none
module sdcc_mc_model
  import sdcc_pkg::*;
(
  output logic ck_o, // true memory clock
  output logic cs_n_o, // chip select, low active
  output logic cke_o, // clock enable
  output logic [CA_W-1:0] ca_o // command/address
);
  logic run = 1'b1;
  initial
  begin
    ck_o = 1'b0;
    cs_n_o = 1'b1;
    cke_o = 1'b1;
    ca_o = '0;
    // link edges kept off the core edges
    #4;
    forever
    begin
      #15;
      ck_o = run ? ~ck_o : 1'b0;
    end
  end
  task automatic send(input logic cs_n, input logic cke, input logic [CA_W-1:0] r,
                      input logic [CA_W-1:0] f);
    @(negedge ck_o);
    cs_n_o <= cs_n;
    cke_o <= cke;
    ca_o <= r;
    @(posedge ck_o);
    ca_o <= f;
    @(negedge ck_o);
    cs_n_o <= 1'b1;
    ca_o <= ~f;
  endtask : send
endmodule : sdcc_mc_model
`default_nettype wire

// ### test/sdcc_cmd_decode_bench.sv
// self-checking bench for the command decode front end
`timescale 1ns/1ps
`default_nettype none
module sdcc_cmd_decode_bench;
  import sdcc_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic link_clk_i, cs_n_i, cke_i, cmd_valid_o, cmd_refused_o, auto_close_flag_o;
  logic all_banks_select_o, clk_stopped_o, exit_wait_o, illegal_o, overrun_o;
  logic [CA_W-1:0] ca_i;
  sdcc_cmd_e cmd_code_o;
  logic [BANK_W-1:0] bank_o;
  logic [ROW_W-1:0] row_o;
  logic [COL_W-1:0] col_o;
  logic [MA_W-1:0] mode_reg_address_o;
  logic [OP_W-1:0] mode_reg_data_o;
  int fail_count = 0;
  int check_count = 0;
  sdcc_cmd_decode #(.STOP_CYC(4)) sdcc_cmd_decode_i (.core_clk_i, .rst_i, .link_clk_i,
    .cs_n_i, .cke_i, .ca_i, .cmd_valid_o, .cmd_refused_o, .cmd_code_o, .bank_o, .row_o,
    .col_o, .auto_close_flag_o, .all_banks_select_o, .mode_reg_address_o,
    .mode_reg_data_o, .clk_stopped_o, .exit_wait_o, .illegal_o, .overrun_o);
  sdcc_mc_model sdcc_mc_model_i (.ck_o(link_clk_i), .cs_n_o(cs_n_i), .cke_o(cke_i),
    .ca_o(ca_i));
  initial
    forever #25 core_clk_i = ~core_clk_i;
  task automatic close_out;
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic fields(input logic [CA_W-1:0] r, input logic [CA_W-1:0] f, input logic mode_register_write);
    chk("bank", 16'(r[9:7]), 16'(bank_o));
    chk("row", 16'({f[9:8], r[6:2], f[7:0]}), 16'(row_o));
    chk("col", 16'({f[9:1], r[6:5], 1'b0}), 16'(col_o));
    chk("auto_close", 16'(f[0]), 16'(auto_close_flag_o));
    chk("all_banks", 16'(r[4]), 16'(all_banks_select_o));
    chk("ma", 16'({f[1:0], r[9:4]}), 16'(mode_reg_address_o));
    chk("op", mode_register_write ? 16'(f[9:2]) : 16'h0, 16'(mode_reg_data_o));
  endtask : fields
  task automatic cmd_x(input logic cs_n, input logic cke, input logic [CA_W-1:0] r,
                       input logic [CA_W-1:0] f, input sdcc_cmd_e exp, input logic refuse);
    logic seen;
    seen = 1'b0;
    sdcc_mc_model_i.send(cs_n, cke, r, f);
    repeat (40)
    begin
      @(posedge core_clk_i);
      #1;
      if (!seen && (cmd_valid_o === 1'b1 || cmd_refused_o === 1'b1))
      begin
        seen = 1'b1;
        chk("refused", 16'(refuse), 16'(cmd_refused_o));
        chk("valid", 16'(!refuse), 16'(cmd_valid_o));
        chk("code", 16'(exp), 16'(cmd_code_o));
        fields(r, f, exp == CMD_MRW);
      end
    end
    chk("answered", 16'(exp != CMD_NOP), 16'(seen));
  endtask : cmd_x
  task automatic cmd(input logic cs_n, input logic cke, input logic [CA_W-1:0] r,
                     input logic [CA_W-1:0] f, input sdcc_cmd_e exp);
    cmd_x(cs_n, cke, r, f, exp, 1'b0);
  endtask : cmd
  task automatic t_opcodes;
    sdcc_cmd_e c[10] = '{CMD_MRW, CMD_MRR, CMD_PER_BANK_REFRESH, CMD_ALL_BANK_REFRESH, CMD_ACT, CMD_WR, CMD_RD,
                        CMD_PRE, CMD_BST, CMD_NOP};
    logic [3:0] o[10] = '{4'h0, 4'h8, 4'h4, 4'hC, 4'h2, 4'h1, 4'h5, 4'hB, 4'h3, 4'h7};
    for (int i = 0; i < 10; i++)
      cmd(1'b0, 1'b1, {6'h2D ^ 6'(i), o[i]}, 10'h2A7 ^ 10'(i * 37), c[i]);
    cmd(1'b1, 1'b1, 10'h000, 10'h3FF, CMD_NOP);
  endtask : t_opcodes
  task automatic t_cke;
    cmd(1'b0, 1'b0, 10'h004, 10'h155, CMD_SRE);
    cmd(1'b1, 1'b1, 10'h000, 10'h0AA, CMD_PDX);
    cmd(1'b1, 1'b0, 10'h3A0, 10'h1B6, CMD_PDE);
    cmd(1'b0, 1'b1, 10'h3A0, 10'h1B6, CMD_ILL);
    cmd(1'b0, 1'b0, 10'h003, 10'h2C3, CMD_DPD);
    cmd(1'b1, 1'b1, 10'h1F0, 10'h00F, CMD_PDX);
    chk("illegal", 16'h1, 16'(illegal_o));
  endtask : t_cke
  task automatic stop_clk;
    sdcc_mc_model_i.run = 1'b0;
    repeat (12) @(posedge core_clk_i);
    #1;
    chk("stopped", 16'h1, 16'(clk_stopped_o));
    chk("exit_wait", 16'h1, 16'(exit_wait_o));
  endtask : stop_clk
  task automatic t_stop;
    int n;
    n = 0;
    stop_clk();
    sdcc_mc_model_i.run = 1'b1;
    while (exit_wait_o === 1'b1 && n < 40)
    begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    chk("exit_time", 16'h1, 16'(n >= 2 && n < 40));
    chk("stopped", 16'h0, 16'(clk_stopped_o));
    cmd(1'b0, 1'b1, 10'h365, 10'h2A7, CMD_RD);
    chk("overrun", 16'h0, 16'(overrun_o));
  endtask : t_stop
  task automatic t_guard;
    // cke low stop: clock kept while the entry command is answered
    cmd(1'b1, 1'b0, 10'h000, 10'h3C3, CMD_PDE);
    stop_clk();
    sdcc_mc_model_i.run = 1'b1;
    repeat (3) @(posedge link_clk_i);
    cmd(1'b1, 1'b1, 10'h0F0, 10'h30C, CMD_PDX);
    // cke high stop: a command right after restart lands in the guard
    stop_clk();
    sdcc_mc_model_i.run = 1'b1;
    cmd_x(1'b0, 1'b1, 10'h2B1, 10'h1E5, CMD_WR, 1'b1);
    cmd(1'b0, 1'b1, 10'h0A0, 10'h2DB, CMD_MRW);
    chk("overrun", 16'h0, 16'(overrun_o));
  endtask : t_guard
  initial
  begin
    #200000;
    fail_count++;
    close_out();
  end
  initial
  begin
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    cmd(1'b0, 1'b1, 10'h3A0, 10'h1B6, CMD_MRW);
    cmd(1'b0, 1'b1, 10'h29B, 10'h155, CMD_PRE);
    t_opcodes();
    t_cke();
    t_stop();
    t_guard();
    close_out();
  end
endmodule : sdcc_cmd_decode_bench
`default_nettype wire
